// >>> core/ccad_host.sv
// Host controller that runs common and attribute memory cycles on a PC Card socket.
// Assumes software on a classic Wishbone slave port and a card on the socket pins.
//
// Contract
// - Attribute accesses are byte wide at even addresses only.
// - Writes to the information structure are invalid and never issued.
// - Soft reset writes one, holds the reset width, then writes zero.
// - Host always writes zero into the two top index bits.
`timescale 1ns/10ps
module ccad_host #(
  parameter int STB_CYC = ccad_pkg::STROBE_CYC,
  parameter int RST_CYC = ccad_pkg::RST_CYC
) (
  // Clock and reset.
  input  wire logic                ref_clk,
  input  wire logic                reset,
  // Wishbone slave.
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [4:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Card socket pins.
  output ccad_pkg::ccad_pins_t     card_pins,
  input  wire logic [15:0]         card_data_i,
  output logic      [15:0]         card_data_o,
  output logic                     card_data_oe
);
  // Refuse settings the counters cannot hold.
  if (STB_CYC < 1 || STB_CYC > 4095 || RST_CYC < 1 || RST_CYC > 4095) begin : g_chk
    $error("ccad_host: cycle counts must lie in 1..4095");
  end

  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_SETUP = 5'b00010,
    S_STRB  = 5'b00100,
    S_HOLD  = 5'b01000,
    S_RWAIT = 5'b10000
  } ccad_state_t;

  ccad_state_t         st_q, st_d;
  ccad_pkg::ccad_op_t  op_q, op_d;
  ccad_pkg::ccad_pins_t pins_q, pins_d;
  logic [11:0]         cnt_q, cnt_d;
  logic [10:0]         addr_q, addr_d;
  logic [15:0]         wdata_q, wdata_d;
  logic [15:0]         rdata_q, rdata_d;
  logic [15:0]         dout_q, dout_d;
  logic                doe_q, doe_d;
  logic                refused_q, refused_d;
  logic                done_q, done_d;
  logic                ph2_q, ph2_d;
  logic                ack_q, ack_d;
  logic [31:0]         rd_q, rd_d;
  logic                wb_req, cmd_wr, bad;
  logic [7:0]          wbyte;
  ccad_pkg::ccad_op_t  new_op;

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign cmd_wr = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ccad_pkg::REG_CMD);

  // Decode a new command; soft reset forces an option register write.
  always_comb begin
    new_op.wr   = wb_dat_i[ccad_pkg::CMD_WR];
    new_op.attr = wb_dat_i[ccad_pkg::CMD_ATTR];
    new_op.wide = wb_dat_i[ccad_pkg::CMD_WIDE];
    new_op.hi   = wb_dat_i[ccad_pkg::CMD_HI];
    new_op.srst = wb_dat_i[ccad_pkg::CMD_SRST];
    if (new_op.srst) begin
      new_op.wr   = 1'b1;
      new_op.attr = 1'b1;
      new_op.wide = 1'b0;
      new_op.hi   = 1'b0;
    end
    bad = 1'b0;
    if (!new_op.srst) begin
      // Attribute space: even bytes on the low enable only.
      bad = new_op.attr & (addr_q[0] | new_op.wide | new_op.hi);
      // No writes into the information structure.
      bad = bad | (new_op.attr & new_op.wr & (addr_q[10:9] == 2'b00));
      // Common words only at even addresses.
      bad = bad | (~new_op.attr & new_op.wide & addr_q[0]);
    end
  end

  // Byte presented to the card; option register writes clear reserved index bits.
  always_comb begin
    wbyte = wdata_q[7:0];
    if (op_q.attr && addr_q == ccad_pkg::COR_ADDR) begin
      wbyte = wdata_q[7:0] & ccad_pkg::COR_RSVD_MASK;
    end
  end

  // Transfer sequencer and socket pin values.
  always_comb begin
    st_d      = st_q;
    op_d      = op_q;
    cnt_d     = cnt_q;
    pins_d    = pins_q;
    dout_d    = dout_q;
    doe_d     = doe_q;
    rdata_d   = rdata_q;
    ph2_d     = ph2_q;
    refused_d = refused_q;
    done_d    = done_q;
    addr_d    = addr_q;
    wdata_d   = wdata_q;
    if (wb_req && wb_we_i && wb_sel_i[1:0] != 2'b00 && st_q == S_IDLE) begin
      if (wb_adr_i == ccad_pkg::REG_ADDR) addr_d = wb_dat_i[10:0];
      if (wb_adr_i == ccad_pkg::REG_WDATA) wdata_d = wb_dat_i[15:0];
    end
    if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ccad_pkg::REG_STATUS) begin
      if (wb_dat_i[ccad_pkg::ST_REFUSED]) refused_d = 1'b0;
      if (wb_dat_i[ccad_pkg::ST_DONE]) done_d = 1'b0;
    end
    unique case (st_q)
      S_IDLE: begin
        pins_d = ccad_pkg::PINS_STANDBY;
        doe_d  = 1'b0;
        if (cmd_wr) begin
          if (bad) begin
            refused_d = 1'b1;
          end else begin
            op_d  = new_op;
            ph2_d = 1'b0;
            if (new_op.srst) begin
              addr_d  = ccad_pkg::COR_ADDR;
              wdata_d = {8'h00, 1'b1, wdata_q[6:0]};
            end
            st_d = S_SETUP;
          end
        end
      end
      S_SETUP: begin
        pins_d.addr  = addr_q;
        pins_d.reg_n = ~op_q.attr;
        // Enable choice steers the byte lanes.
        pins_d.ce1_n = op_q.hi & ~op_q.wide;
        pins_d.ce2_n = ~(op_q.hi | op_q.wide);
        doe_d        = op_q.wr;
        if (op_q.wide) dout_d = wdata_q;
        else if (op_q.hi) dout_d = {wbyte, 8'h00};
        else dout_d = {8'h00, wbyte};
        // The full count keeps the strobe low for exactly STB_CYC cycles.
        cnt_d = 12'(STB_CYC);
        st_d  = S_STRB;
      end
      S_STRB: begin
        pins_d.oe_n = op_q.wr;
        pins_d.we_n = ~op_q.wr;
        if (cnt_q == 12'h000) begin
          if (!op_q.wr) begin
            if (op_q.wide) rdata_d = card_data_i;
            else if (op_q.hi) rdata_d = {8'h00, card_data_i[15:8]};
            else rdata_d = {8'h00, card_data_i[7:0]};
          end
          pins_d.oe_n = 1'b1;
          pins_d.we_n = 1'b1;
          st_d        = S_HOLD;
        end else begin
          cnt_d = cnt_q - 12'h001;
        end
      end
      S_HOLD: begin
        pins_d = ccad_pkg::PINS_STANDBY;
        doe_d  = 1'b0;
        if (op_q.srst && !ph2_q) begin
          cnt_d = 12'(RST_CYC - 1);
          st_d  = S_RWAIT;
        end else begin
          done_d = 1'b1;
          st_d   = S_IDLE;
        end
      end
      S_RWAIT: begin
        // Hold the reset bit for the full width, then clear it.
        if (cnt_q == 12'h000) begin
          wdata_d[ccad_pkg::COR_SRST_BIT] = 1'b0;
          ph2_d = 1'b1;
          st_d  = S_SETUP;
        end else begin
          cnt_d = cnt_q - 12'h001;
        end
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q      <= S_IDLE;
      op_q      <= '0;
      cnt_q     <= 12'h000;
      pins_q    <= ccad_pkg::PINS_STANDBY;
      dout_q    <= 16'h0000;
      doe_q     <= 1'b0;
      rdata_q   <= 16'h0000;
      ph2_q     <= 1'b0;
      refused_q <= 1'b0;
      done_q    <= 1'b0;
      addr_q    <= 11'h000;
      wdata_q   <= 16'h0000;
    end else begin
      st_q      <= st_d;
      op_q      <= op_d;
      cnt_q     <= cnt_d;
      pins_q    <= pins_d;
      dout_q    <= dout_d;
      doe_q     <= doe_d;
      rdata_q   <= rdata_d;
      ph2_q     <= ph2_d;
      refused_q <= refused_d;
      done_q    <= done_d;
      addr_q    <= addr_d;
      wdata_q   <= wdata_d;
    end
  end

  // Wishbone read mux and one-cycle acknowledge.
  always_comb begin
    ack_d = wb_req;
    rd_d  = rd_q;
    if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        ccad_pkg::REG_ADDR:   rd_d = {21'h000000, addr_q};
        ccad_pkg::REG_WDATA:  rd_d = {16'h0000, wdata_q};
        ccad_pkg::REG_RDATA:  rd_d = {16'h0000, rdata_q};
        ccad_pkg::REG_STATUS: rd_d = {29'h00000000, done_q, refused_q, st_q != S_IDLE};
        default:              rd_d = 32'h00000000;
      endcase
    end
  end

  // Bus answer registers.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_q <= 1'b0;
      rd_q  <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      rd_q  <= rd_d;
    end
  end

  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = rd_q;
  assign card_pins    = pins_q;
  assign card_data_o  = dout_q;
  assign card_data_oe = doe_q;

  // Strobe length in cycles, used only by the width check.
  logic [11:0] slen_q, slen_d;

  always_comb begin
    slen_d = 12'h000;
    if (!(pins_q.oe_n && pins_q.we_n)) slen_d = slen_q + 12'h001;
  end

  // Strobe length register.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      slen_q <= 12'h000;
    end else begin
      slen_q <= slen_d;
    end
  end

  // Checks on the socket side.
  AST_ATTR_EVEN: assert property (@(posedge ref_clk) disable iff (reset)
    !card_pins.reg_n |-> !card_pins.ce1_n && card_pins.ce2_n && !card_pins.addr[0])
    else $error("Attribute access odd, word wide or on the high enable.");
  AST_STROBE_WIDTH: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(card_pins.oe_n & card_pins.we_n) |-> slen_q == 12'(STB_CYC))
    else $error("Strobe width differs from the configured cycle count.");
  AST_NO_CIS_WRITE: assert property (@(posedge ref_clk) disable iff (reset)
    !card_pins.reg_n && !card_pins.we_n |-> card_pins.addr[10:9] != 2'b00)
    else $error("Write issued into the information structure.");
  AST_COR_RSVD: assert property (@(posedge ref_clk) disable iff (reset)
    !card_pins.reg_n && !card_pins.we_n && card_pins.addr == ccad_pkg::COR_ADDR
    |-> card_data_oe && card_data_o[5:4] == 2'b00)
    else $error("Reserved index bits written as one.");
  AST_SRST_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(st_q == S_RWAIT) |-> (st_q == S_RWAIT) [*8])
    else $error("Soft reset width cut short.");
  AST_SRST_CLEAR: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(st_q == S_RWAIT) |-> !wdata_q[ccad_pkg::COR_SRST_BIT] ##1 st_q == S_STRB)
    else $error("Soft reset not followed by a clearing write.");
  AST_STANDBY: assert property (@(posedge ref_clk) disable iff (reset)
    st_q == S_IDLE |=> card_pins.ce1_n && card_pins.ce2_n && !card_data_oe)
    else $error("Card not left in standby while idle.");
  AST_STROBE: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(card_pins.oe_n & card_pins.we_n) |-> !card_pins.ce1_n || !card_pins.ce2_n)
    else $error("Strobe without a card enable.");
  CVR_WORD_READ: cover property (@(posedge ref_clk) disable iff (reset)
    !card_pins.oe_n && !card_pins.ce1_n && !card_pins.ce2_n);
  CVR_REFUSE: cover property (@(posedge ref_clk) disable iff (reset) $rose(refused_q));
  CVR_HIGH_BYTE: cover property (@(posedge ref_clk) disable iff (reset)
    !card_pins.oe_n && card_pins.ce1_n && !card_pins.ce2_n);
  CVR_SRST: cover property (@(posedge ref_clk) disable iff (reset)
    ph2_q && st_q == S_HOLD);
endmodule : ccad_host

// >>> core/ccad_pkg.sv
// Shared constants and types for the card attribute/common memory host controller.
// Assumes a 25 MHz system clock and a card reached over PC Card memory pins.
package ccad_pkg;
  // Register byte offsets on the Wishbone side.
  localparam logic [4:0] REG_CMD    = 5'h00;
  localparam logic [4:0] REG_ADDR   = 5'h04;
  localparam logic [4:0] REG_WDATA  = 5'h08;
  localparam logic [4:0] REG_RDATA  = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;
  // Command register field positions.
  localparam int CMD_WR   = 0;
  localparam int CMD_ATTR = 1;
  localparam int CMD_WIDE = 2;
  localparam int CMD_HI   = 3;
  localparam int CMD_SRST = 4;
  // Status register field positions.
  localparam int ST_BUSY    = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_DONE    = 2;
  // Card side layout: option register address and its fields.
  localparam logic [10:0] COR_ADDR        = 11'h200;
  localparam int          COR_SRST_BIT    = 7;
  localparam int          COR_LEVEL_BIT   = 6;
  localparam logic [7:0]  COR_RSVD_MASK   = 8'hcf;
  localparam logic [7:0]  COR_RESET_VALUE = 8'h00;
  // Timing, each time in its own unit and the derived cycle count.
  localparam int CLK_NS       = 40;
  localparam int STROBE_NS    = 300;
  localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_WIDTH_US = 100;
  localparam int RST_CYC      = (RST_WIDTH_US * 1000 + CLK_NS - 1) / CLK_NS;
  // Transfer command as latched at start.
  typedef struct packed {
    logic wr;
    logic attr;
    logic wide;
    logic hi;
    logic srst;
  } ccad_op_t;
  // Card control and address pins, all driven by this controller.
  typedef struct packed {
    logic        ce1_n;
    logic        ce2_n;
    logic        reg_n;
    logic        oe_n;
    logic        we_n;
    logic [10:0] addr;
  } ccad_pins_t;
  localparam ccad_pins_t PINS_STANDBY = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 11'h000};
endpackage : ccad_pkg

// >>> dv/ccad_card_model.sv
// Behavioural card on the socket: option and group registers, a small common memory.
// Assumes the host drives the socket pins and samples card_data_i on ref_clk.
`timescale 1ns/10ps
module ccad_card_model (
  // Clock and hardware reset.
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  // Socket pins.
  input  wire ccad_pkg::ccad_pins_t card_pins,
  input  wire logic [15:0]          card_data_o,
  input  wire logic                 card_data_oe,
  output logic      [15:0]          card_data_i
);
  logic [7:0]  cor_q;
  logic [7:0]  mem [0:31];
  logic [15:0] last_q = 16'h0000;
  int          n_acc = 0;
  int          n_bad = 0;
  int          srst_len = 0;
  wire logic        attr = !card_pins.reg_n;
  wire logic        sel = !(card_pins.ce1_n && card_pins.ce2_n);
  wire logic [10:0] a = card_pins.addr;
  wire logic        grp = (a[10:9] == 2'b01) && (a[8:4] == 5'h00) && !a[0];

  // Read data by space and lane; an undriven lane shows the inverse of its last value.
  always_comb begin
    card_data_i = ~last_q;
    if (!card_pins.oe_n && sel) begin
      if (attr) begin
        if (grp) card_data_i[7:0] = (a[3:1] == 3'h0) ? cor_q : {4'h0, a[3:0]};
        else card_data_i[7:0] = 8'hc1;
      end else if (!card_pins.ce1_n && !card_pins.ce2_n) begin
        card_data_i = {mem[{a[4:1], 1'b1}], mem[{a[4:1], 1'b0}]};
      end else if (!card_pins.ce1_n) card_data_i[7:0] = mem[a[4:0]];
      else card_data_i[15:8] = mem[a[4:0]];
    end
  end

  // Writes land on the rising write strobe; the host must drive the lanes then.
  always @(posedge card_pins.we_n) begin
    if (sel && !card_data_oe) n_bad++;
    if (sel && attr && grp && a[3:1] == 3'h0) cor_q <= card_data_o[7:0];
    else if (sel && !attr) begin
      if (!card_pins.ce1_n && !card_pins.ce2_n) begin
        mem[{a[4:1], 1'b0}] <= card_data_o[7:0];
        mem[{a[4:1], 1'b1}] <= card_data_o[15:8];
      end else if (!card_pins.ce1_n) mem[a[4:0]] <= card_data_o[7:0];
      else mem[a[4:0]] <= card_data_o[15:8];
    end
  end

  // Strobes are counted, invalid accesses and lane fights on reads separately.
  always @(negedge card_pins.oe_n or negedge card_pins.we_n) begin
    n_acc++;
    if (sel && !card_pins.oe_n && card_data_oe) n_bad++;
    if (sel && attr && (a[0] || card_pins.ce1_n || (!card_pins.we_n && a[10:9] == 2'b00)))
      n_bad++;
  end

  // Hardware reset clears the option register; soft reset time is measured.
  always @(posedge ref_clk) begin
    last_q <= card_data_i;
    if (reset) cor_q <= 8'h00;
    if (cor_q[7]) srst_len++;
  end
endmodule : ccad_card_model

// >>> dv/tb.sv
// Self-checking bench for the socket host controller with a card model behind it.
// Assumes a 25 MHz clock and software access over classic Wishbone.
`timescale 1ns/10ps
module tb;
  logic        ref_clk, reset, cyc, stb, we, ack, oe;
  logic [4:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, dat_o, q, st;
  logic [15:0] d_in, d_out;
  ccad_pkg::ccad_pins_t pins;
  int          errors = 0;
  int          n_checks = 0;
  localparam logic [4:0]  RC [5] = '{5'h02, 5'h06, 5'h0a, 5'h03, 5'h04};
  localparam logic [10:0] RA [5] = '{11'h201, 11'h200, 11'h200, 11'h000, 11'h00b};

  ccad_host #(.STB_CYC(8), .RST_CYC(10)) uut (
    .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .card_pins(pins), .card_data_i(d_in), .card_data_o(d_out), .card_data_oe(oe));
  ccad_card_model mdl (.ref_clk(ref_clk), .reset(reset), .card_pins(pins),
    .card_data_o(d_out), .card_data_oe(oe), .card_data_i(d_in));

  // Clock at 40 ns period.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic conclude;
    if (errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One classic Wishbone cycle; read data lands in q.
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    @(posedge ref_clk);
    while (ack !== 1'b1) @(posedge ref_clk);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // One card transfer: set up, start, poll, fetch the result, clear status.
  task automatic op(input logic [4:0] c, input logic [10:0] ad, input logic [15:0] wd,
                    input logic rf);
    int n0;
    n0 = mdl.n_acc;
    wb(1'b1, ccad_pkg::REG_ADDR, {21'h0, ad});
    wb(1'b1, ccad_pkg::REG_WDATA, {16'h0, wd});
    wb(1'b1, ccad_pkg::REG_CMD, {27'h0, c});
    do wb(1'b0, ccad_pkg::REG_STATUS, 32'h0); while (q[2:1] == 2'b00);
    st = q;
    chk({29'h0, st[2:0]}, {29'h0, ~rf, rf, 1'b0});
    if (rf) chk(mdl.n_acc, n0);
    chk({16'h0, pins}, {16'h0, ccad_pkg::PINS_STANDBY});
    chk({31'h0, oe}, 32'h0);
    wb(1'b0, ccad_pkg::REG_RDATA, 32'h0);
    wb(1'b1, ccad_pkg::REG_STATUS, 32'h6);
  endtask : op

  task automatic t_rst;
    op(5'h02, 11'h200, 16'h0, 1'b0);
    chk(q, 32'h0);
  endtask : t_rst

  task automatic t_cor;
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {1'b0, i[0], 2'b11, 2'b00, i[1:0]};
      op(5'h03, 11'h200, {8'h0, v}, 1'b0);
      chk({24'h0, mdl.cor_q}, {24'h0, v & 8'hcf});
      op(5'h02, 11'h200, 16'h0, 1'b0);
      chk(q, {24'h0, v & 8'hcf});
    end
  endtask : t_cor

  task automatic t_grp;
    for (int i = 1; i < 4; i++) begin
      op(5'h02, {8'h40, i[1:0], 1'b0}, 16'h0, 1'b0);
      chk(q, {29'h0, i[1:0], 1'b0});
    end
  endtask : t_grp

  task automatic t_com;
    op(5'h05, 11'h00a, 16'hbeef, 1'b0);
    op(5'h04, 11'h00a, 16'h0, 1'b0);
    chk(q, 32'hbeef);
    op(5'h01, 11'h010, 16'h005a, 1'b0);
    op(5'h09, 11'h011, 16'ha5a5, 1'b0);
    op(5'h04, 11'h010, 16'h0, 1'b0);
    chk(q, 32'ha55a);
    op(5'h08, 11'h011, 16'h0, 1'b0);
    chk(q, 32'h00a5);
    op(5'h00, 11'h010, 16'h0, 1'b0);
    chk(q, 32'h005a);
  endtask : t_com

  task automatic t_ref;
    for (int i = 0; i < 5; i++) op(RC[i], RA[i], 16'h1234, 1'b1);
    chk(mdl.n_bad, 0);
  endtask : t_ref

  task automatic t_srst;
    int n;
    n = mdl.srst_len;
    op(5'h10, 11'h000, 16'h0073, 1'b0);
    chk({24'h0, mdl.cor_q}, 32'h43);
    chk({31'h0, (mdl.srst_len - n) >= 10}, 32'h1);
    wb(1'b0, ccad_pkg::REG_ADDR, 32'h0);
    chk(q, 32'h200);
    wb(1'b0, ccad_pkg::REG_WDATA, 32'h0);
    chk(q, 32'h73);
    op(5'h02, 11'h200, 16'h0, 1'b0);
    chk(q, 32'h43);
    chk(mdl.n_bad, 0);
  endtask : t_srst

  // Main sequence after 16 cycles of reset.
  initial begin
    {cyc, stb, we} = 3'b000;
    adr = 5'h00;
    sel = 4'hf;
    dat = 32'h0;
    reset = 1'b1;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    t_rst();
    t_cor();
    t_grp();
    t_com();
    t_ref();
    t_srst();
    conclude();
  end

  // Watchdog far beyond the expected run of under a thousand cycles.
  initial begin
    #800000;
    errors++;
    conclude();
  end
endmodule : tb
